//--- mdma_arb.sv
// shared bus arbiter between core and transfer engine
`timescale 1ns/1ps
`default_nettype none
module mdma_arb (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // requests and grants
  mdma_arb_if.arb a
);
  import mdma_pkg::*;
  logic core_last;
  mdma_pol_t pol_q;
  logic pol_ok;
  wire logic both = a.core_req & a.eng_req;
  // policy latched only when no access is in flight
  assign pol_ok = ~(a.core_req | a.eng_req); // RULE_12
  wire logic rot_core = ~core_last; // RULE_07
  wire logic pick_core = (pol_q == MDMA_POL_CORE) ? 1'b1 : // RULE_05
                         (pol_q == MDMA_POL_ENG) ? 1'b0 : rot_core; // RULE_06
  assign a.core_gnt = a.core_req & (~a.eng_req | pick_core);
  assign a.eng_gnt = a.eng_req & (~a.core_req | ~pick_core);
  always_ff @(posedge clk) begin
    if (!rstn) begin
      pol_q <= MDMA_POL_CORE;
      core_last <= 1'b0;
    end else begin
      if (pol_ok) pol_q <= a.pol; // RULE_12
      if (pol_ok && pol_q != a.pol) core_last <= 1'b0; // RULE_07
      else if (both && pol_q == MDMA_POL_ROT) core_last <= pick_core; // RULE_07
    end
  end
endmodule // mdma_arb
`default_nettype wire

//--- mdma_arb_if.sv
// request and grant bundle between the engine and its bus arbiter
`timescale 1ns/1ps
`default_nettype none
interface mdma_arb_if;
  logic core_req;
  logic eng_req;
  logic core_gnt;
  logic eng_gnt;
  mdma_pkg::mdma_pol_t pol;
  modport arb (input core_req, input eng_req, input pol, output core_gnt, output eng_gnt);
  modport eng (output core_req, output eng_req, output pol, input core_gnt, input eng_gnt);
endinterface
`default_nettype wire

//--- mdma_chk.sv
// assertion checker watching the transfer engine top ports
`timescale 1ns/1ps
`default_nettype none
module mdma_chk (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // shared port arbitration
  input wire logic core_req,
  input wire logic core_gnt,
  // engine bus
  input wire logic [23:0] mem_addr,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [31:0] mem_wdata,
  input wire logic [31:0] mem_rdata,
  input wire logic mem_ack,
  input wire mdma_pkg::mdma_state_t state_o
);
  import mdma_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  rw_excl_a: assert property (!(mem_rd && mem_wr))
    else $error("read and write strobes together");
  read_to_write_a: assert property (mem_rd && mem_ack |=>
    state_o == MDMA_WRITE && mem_wdata == $past(mem_rdata)) else $error("read word not carried");
  write_next_a: assert property (mem_wr && mem_ack |=> state_o != MDMA_WRITE)
    else $error("write repeated after ack");
  idle_quiet_a: assert property (state_o == MDMA_IDLE |-> !mem_rd && !mem_wr)
    else $error("bus access while idle");
  src_hold_a: assert property (state_o == MDMA_READ && !(mem_rd && mem_ack) |=>
    $stable(mem_addr)) else $error("source address moved mid read");
  bus_excl_a: assert property (!(core_gnt && (mem_rd || mem_wr)))
    else $error("both parties granted");
  grant_cause_a: assert property (core_gnt |-> core_req)
    else $error("core granted without request");
  core_free_a: assert property (core_req && state_o == MDMA_IDLE |-> core_gnt)
    else $error("uncontended core request refused");
endmodule // mdma_chk
`default_nettype wire

//--- mdma_mem.sv
// word memory with optional wait states on the engine bus
`timescale 1ns/1ps
`default_nettype none
module mdma_mem (
  // clock and pacing
  input wire logic clk,
  input wire logic slow,
  // engine bus
  input wire logic [23:0] mem_addr,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [31:0] mem_wdata,
  output logic [31:0] mem_rdata,
  output logic mem_ack
);
  logic [31:0] mem [64];
  logic tog = 1'b0;
  // slow mode acks every other cycle
  assign mem_ack = (mem_rd || mem_wr) && (!slow || tog);
  // inverted word outside an acked read, so stale data never looks right
  assign mem_rdata = (mem_rd && mem_ack) ? mem[mem_addr[5:0]] : ~mem[mem_addr[5:0]];
  always @(posedge clk) begin
    tog <= !tog;
    if (mem_wr && mem_ack)
      mem[mem_addr[5:0]] <= mem_wdata;
  end
endmodule // mdma_mem
`default_nettype wire

//--- mdma_pkg.sv
// types shared by the transfer engine modules
package mdma_pkg;
  typedef enum logic [1:0] {
    MDMA_POL_CORE = 2'b00,
    MDMA_POL_ENG = 2'b01,
    MDMA_POL_ROT = 2'b10
  } mdma_pol_t;
  typedef enum logic [1:0] {
    MDMA_IDLE = 2'b00,
    MDMA_READ = 2'b01,
    MDMA_WRITE = 2'b10
  } mdma_state_t;
endpackage

//--- mdma_regs.svh
// register map, field positions, reset values and the rule summary for the transfer engine
// Contract
// RULE_01: each transfer first reads the word at the source address, then writes it to the destination address.
// RULE_02: after each completed transfer both addresses step up or down as the control register selects.
// RULE_03: transfers run back to back on the engine's own bus until the transfer counter reaches zero.
// RULE_04: when the counter reaches zero an interrupt is raised if it is enabled.
// RULE_05: under the core-priority policy the core always wins a contended access.
// RULE_06: under the engine-priority policy the engine always wins a contended access.
// RULE_07: under the rotating policy grants alternate, the core taking the first one.
// RULE_08: an optional second channel has its own addresses, counter and priority setting.
// RULE_09: peripheral registers are plain memory locations usable as source or destination.
// RULE_10: the engine drives its own address and data bus, in parallel with the core; the code strobes it only on its arbiter grant, never with the core.
// RULE_11: the counter drops by one per read-write pair and no transfer starts at zero.
// RULE_12: the policy comes from a software field and changes only at a grant boundary.
`ifndef MDMA_REGS_SVH
`define MDMA_REGS_SVH
`define MDMA_OFF_CTRL 12'h000
`define MDMA_OFF_SRC0 12'h004
`define MDMA_OFF_DST0 12'h008
`define MDMA_OFF_CNT0 12'h00c
`define MDMA_OFF_SRC1 12'h010
`define MDMA_OFF_DST1 12'h014
`define MDMA_OFF_CNT1 12'h018
`define MDMA_OFF_STAT 12'h01c
`define MDMA_OFF_MASK 12'h020
`define MDMA_OFF_BUSY 12'h024
`define MDMA_CTRL_START0 0
`define MDMA_CTRL_DEC0 1
`define MDMA_CTRL_START1 2
`define MDMA_CTRL_DEC1 3
`define MDMA_CTRL_POL_LO 4
`define MDMA_CTRL_CH1SEL 6
`define MDMA_CTRL_RST 32'h0000_0000
`define MDMA_MASK_RST 2'h0
`define MDMA_ADDR_W 24
`endif

//--- mdma_top.sv
// memory-to-memory transfer engine with apb registers and bus arbiter
`timescale 1ns/1ps
`default_nettype none
`include "mdma_regs.svh"
module mdma_top (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // core request to the shared memory port
  input wire logic core_req,
  output logic core_gnt,
  // engine memory bus
  output logic [23:0] mem_addr,
  output logic mem_rd,
  output logic mem_wr,
  output logic [31:0] mem_wdata,
  input wire logic [31:0] mem_rdata,
  input wire logic mem_ack,
  // interrupt
  output logic irq,
  // channel state
  output mdma_pkg::mdma_state_t state_o
);
  import mdma_pkg::*;
  // second channel is built in; software sets its start bit to use it
  logic [31:0] ctrl;
  logic [23:0] src [2];
  logic [23:0] dst [2];
  logic [23:0] cnt [2];
  logic [1:0] stat;
  logic [1:0] mask;
  logic [1:0] run;
  logic cur;
  logic [31:0] data;
  mdma_state_t state;
  mdma_arb_if arb_bus ();

  mdma_arb u_arb (
    .clk(clk),
    .rstn(rstn),
    .a(arb_bus.arb)
  );

  wire logic wr_en = psel & penable & pwrite;
  wire logic rd_en = psel & penable & ~pwrite;
  wire logic hit_ctrl = paddr == `MDMA_OFF_CTRL;
  wire logic hit_src0 = paddr == `MDMA_OFF_SRC0;
  wire logic hit_dst0 = paddr == `MDMA_OFF_DST0;
  wire logic hit_cnt0 = paddr == `MDMA_OFF_CNT0;
  wire logic hit_src1 = paddr == `MDMA_OFF_SRC1;
  wire logic hit_dst1 = paddr == `MDMA_OFF_DST1;
  wire logic hit_cnt1 = paddr == `MDMA_OFF_CNT1;
  wire logic hit_stat = paddr == `MDMA_OFF_STAT;
  wire logic hit_mask = paddr == `MDMA_OFF_MASK;
  wire logic hit_busy = paddr == `MDMA_OFF_BUSY;
  wire logic hit_any = hit_ctrl | hit_src0 | hit_dst0 | hit_cnt0 | hit_src1 | hit_dst1 |
                       hit_cnt1 | hit_stat | hit_mask | hit_busy;
  // unmapped addresses answer with pslverr, reads give zero
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit_any;

  wire logic [1:0] dec = {ctrl[`MDMA_CTRL_DEC1], ctrl[`MDMA_CTRL_DEC0]};
  wire logic [1:0] start = {wr_en & hit_ctrl & pwdata[`MDMA_CTRL_START1],
                            wr_en & hit_ctrl & pwdata[`MDMA_CTRL_START0]};
  // each channel picks its own policy; the active channel's one steers the arbiter
  wire mdma_pol_t pol_ch0 = mdma_pol_t'(ctrl[`MDMA_CTRL_POL_LO +: 2]); // RULE_08
  wire mdma_pol_t pol_ch1 = mdma_pol_t'(ctrl[`MDMA_CTRL_CH1SEL +: 2]); // RULE_08
  // while idle, steer by the channel about to start, so its policy is latched before contention unless the core already requests
  wire logic pol_sel = (state != MDMA_IDLE) ? cur : (can0 ? 1'b0 : (can1 ? 1'b1 : cur));
  assign arb_bus.pol = pol_sel ? pol_ch1 : pol_ch0; // RULE_12
  assign arb_bus.core_req = core_req;
  assign arb_bus.eng_req = state != MDMA_IDLE;
  assign core_gnt = arb_bus.core_gnt;
  wire logic gnt = arb_bus.eng_gnt;

  // engine bus strobes only on the arbiter's engine grant, never alongside a core grant
  assign mem_rd = (state == MDMA_READ) & gnt; // RULE_10
  assign mem_wr = (state == MDMA_WRITE) & gnt; // RULE_10
  // peripherals need no special path: any address is a plain word location
  assign mem_addr = (state == MDMA_WRITE) ? dst[cur] : src[cur]; // RULE_09
  assign mem_wdata = data;
  wire logic rd_done = mem_rd & mem_ack;
  wire logic wr_done = mem_wr & mem_ack;
  wire logic [23:0] next_cnt = cnt[cur] - 24'h000001;
  wire logic last = wr_done & (next_cnt == 24'h000000);
  // pick a channel with nonzero count, channel 0 first
  wire logic can0 = run[0] & (cnt[0] != 24'h000000); // RULE_11
  wire logic can1 = run[1] & (cnt[1] != 24'h000000); // RULE_11
  wire logic [23:0] next_src = dec[cur] ? src[cur] - 24'h000001 : src[cur] + 24'h000001;
  wire logic [23:0] next_dst = dec[cur] ? dst[cur] - 24'h000001 : dst[cur] + 24'h000001;
  wire logic [1:0] done_ev = {last & cur, last & ~cur};
  assign irq = |(stat & mask); // RULE_04
  assign state_o = state;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      ctrl <= `MDMA_CTRL_RST;
      mask <= `MDMA_MASK_RST;
    end else begin
      if (wr_en && hit_ctrl) ctrl <= pwdata & 32'h0000_00fa;
      if (wr_en && hit_mask) mask <= pwdata[1:0];
    end
  end

  // status: set by completion wins over a write-one clear
  always_ff @(posedge clk) begin
    if (!rstn) stat <= 2'h0;
    else stat <= (stat & ~((wr_en && hit_stat) ? pwdata[1:0] : 2'h0)) | done_ev; // RULE_04
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      src[0] <= 24'h000000;
      dst[0] <= 24'h000000;
      cnt[0] <= 24'h000000;
      src[1] <= 24'h000000;
      dst[1] <= 24'h000000;
      cnt[1] <= 24'h000000;
    end else if (wr_done) begin
      src[cur] <= next_src; // RULE_02
      dst[cur] <= next_dst; // RULE_02
      cnt[cur] <= next_cnt; // RULE_11
    end else if (wr_en && state == MDMA_IDLE) begin
      // address and count writes are ignored while a channel moves data
      if (hit_src0) src[0] <= pwdata[23:0];
      if (hit_dst0) dst[0] <= pwdata[23:0];
      if (hit_cnt0) cnt[0] <= pwdata[23:0];
      if (hit_src1) src[1] <= pwdata[23:0];
      if (hit_dst1) dst[1] <= pwdata[23:0];
      if (hit_cnt1) cnt[1] <= pwdata[23:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      state <= MDMA_IDLE;
      cur <= 1'b0;
      run <= 2'h0;
      data <= 32'h0000_0000;
    end else begin
      run <= (run | start) & ~done_ev;
      unique case (state)
        MDMA_IDLE: begin
          if (can0) begin
            cur <= 1'b0;
            state <= MDMA_READ; // RULE_11
          end else if (can1) begin
            cur <= 1'b1;
            state <= MDMA_READ; // RULE_11
          end else begin
            run <= start;
          end
        end
        MDMA_READ: begin
          if (rd_done) begin
            data <= mem_rdata; // RULE_01
            state <= MDMA_WRITE; // RULE_01
          end
        end
        MDMA_WRITE: begin
          if (wr_done) state <= last ? MDMA_IDLE : MDMA_READ; // RULE_03
        end
        default: state <= MDMA_IDLE;
      endcase
    end
  end

  wire logic [31:0] rd_mux =
    hit_ctrl ? ctrl :
    hit_src0 ? {8'h00, src[0]} :
    hit_dst0 ? {8'h00, dst[0]} :
    hit_cnt0 ? {8'h00, cnt[0]} :
    hit_src1 ? {8'h00, src[1]} :
    hit_dst1 ? {8'h00, dst[1]} :
    hit_cnt1 ? {8'h00, cnt[1]} :
    hit_stat ? {30'h0, stat} :
    hit_mask ? {30'h0, mask} :
    hit_busy ? {27'h0, cur, run, state} : 32'h0000_0000;
  assign prdata = rd_en ? rd_mux : 32'h0000_0000;
endmodule // mdma_top
`default_nettype wire

//--- mdma_top_tb.sv
// self-checking bench: copy jobs on both channels, zero count, core hold, bad address
`timescale 1ns/1ps
`default_nettype none
module mdma_top_tb;
  import mdma_pkg::*;
  logic clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, core_req = 0, slow = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, mem_rdata, mem_wdata, q;
  logic pready, pslverr, core_gnt, mem_rd, mem_wr, mem_ack, irq, e;
  logic [23:0] mem_addr;
  mdma_state_t state_o;
  int err_total = 0, samples_checked = 0;
  typedef struct {logic ch, dec; int cnt; logic [1:0] pol; logic core, slow, mask;} mdma_row_t;
  mdma_row_t rows [4] = '{'{0, 0, 3, 0, 0, 0, 1}, '{0, 1, 2, 1, 1, 1, 1},
    '{1, 0, 2, 2, 1, 0, 0}, '{1, 1, 1, 0, 0, 1, 1}};
  mdma_top mdma_top_i (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .core_req(core_req), .core_gnt(core_gnt), .mem_addr(mem_addr), .mem_rd(mem_rd),
    .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack),
    .irq(irq), .state_o(state_o));
  mdma_mem mdma_mem_i (.clk(clk), .slow(slow), .mem_addr(mem_addr), .mem_rd(mem_rd),
    .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack));
  initial begin
    forever #2.5 clk = ~clk;
  end
  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // bounded wait: for pready when flag is 1, for idle engine otherwise
  task automatic hold(input logic bus);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while ((bus ? pready !== 1'b1 : state_o !== MDMA_IDLE) && n < 300);
    if (n >= 300) begin
      err_total++;
      stop_test();
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    hold(1);
    q = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge clk);
  endtask
  initial begin
    int st, c;
    logic [11:0] b;
    repeat (12) @(posedge clk);
    rstn <= 1;
    @(posedge clk);
    apb(0, 12'h000, 0);
    chk("ctrl after reset", 0, q);
    foreach (rows[i]) begin
      for (int k = 0; k < 64; k++) mdma_mem_i.mem[k] = {8'(i), 24'(k)};
      st = rows[i].dec ? -1 : 1;
      b = rows[i].ch ? 12'h010 : 12'h004;
      slow <= rows[i].slow;
      apb(1, b, 20);
      apb(1, b + 12'h004, 40);
      apb(1, b + 12'h008, rows[i].cnt);
      apb(1, 12'h020, 32'(rows[i].mask) << rows[i].ch);
      // policy settles while nobody requests, then start
      c = (rows[i].pol << (rows[i].ch ? 6 : 4)) | (rows[i].dec << (rows[i].ch ? 3 : 1));
      apb(1, 12'h000, c);
      apb(1, 12'h000, c | (rows[i].ch ? 4 : 1));
      core_req <= rows[i].core;
      hold(0);
      for (int k = 0; k <= rows[i].cnt; k++)
        chk("copied word", {8'(i), 24'(k < rows[i].cnt ? 20 + k * st : 40 + k * st)},
          mdma_mem_i.mem[40 + k * st]);
      apb(0, 12'h01c, 0);
      chk("done status", 32'h1 << rows[i].ch, q);
      chk("irq", 32'(rows[i].mask), 32'(irq));
      apb(1, 12'h01c, 3);
      chk("irq cleared", 0, 32'(irq));
      core_req <= 0;
    end
    apb(1, 12'h000, 1);
    repeat (3) @(posedge clk);
    chk("zero count start", 32'(MDMA_IDLE), 32'(state_o));
    apb(1, 12'h00c, 1);
    apb(1, 12'h000, 1);
    core_req <= 1;
    repeat (8) @(posedge clk);
    chk("engine held by core", 32'(MDMA_READ), 32'(state_o));
    chk("core granted", 1, 32'(core_gnt));
    chk("engine strobe off", 0, 32'(mem_rd));
    core_req <= 0;
    hold(0);
    apb(0, 12'h040, 0);
    chk("unmapped error", 1, 32'(e));
    chk("unmapped data", 0, q);
    stop_test();
  end
endmodule // mdma_top_tb
bind mdma_top mdma_chk mdma_chk_i (.clk(clk), .rstn(rstn), .core_req(core_req),
  .core_gnt(core_gnt), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
  .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack), .state_o(state_o));
`default_nettype wire
